// *** sdsr_pkg.sv ***
// Package of constants for the servo device status readout block
// Functional notes
// - Function 03h reads group; device answers it
// - Input group returns entry count 04h
// - Input bit reads 1 when on, 0 off
// - Four distinct input words; word one bits 0-2
// - Clutch and cam bits need firmware C1
// - Output object at 2C13h, single-object reads only
// - Count byte plus four words, nine registers
// - Output group returns entry count 04h
// - Output bit reads 1 when on, 0 off
`default_nettype none
package sdsr_pkg;

	// ****************************************
	// Protocol codes
	// ****************************************
	localparam logic [7:0]  FUNC_READ_HOLDING = 8'h03;
	localparam logic [7:0]  EXC_BAD_FUNCTION  = 8'h01;
	localparam logic [7:0]  EXC_BAD_ADDRESS   = 8'h02;
	localparam logic [15:0] ADDR_INPUT_GROUP  = 16'h2c12;
	localparam logic [15:0] ADDR_OUTPUT_GROUP = 16'h2c13;
	localparam logic [15:0] GROUP_REG_COUNT   = 16'h0009;
	localparam logic [7:0]  ENTRY_COUNT       = 8'h04;
	localparam logic [3:0]  LAST_REG_INDEX    = 4'h8;

	// ****************************************
	// Assigned bit masks
	// ****************************************
	localparam logic [31:0] IN_MASK_ONE        = 32'h3914ffff;
	localparam logic [31:0] IN_MASK_TWO        = 32'h01ff0006;
	localparam logic [31:0] IN_MASK_TWO_C1     = 32'h06000000;
	localparam logic [31:0] IN_MASK_THREE      = 32'hfff13e7b;
	localparam logic [31:0] IN_MASK_FOUR       = 32'h00007fff;
	localparam logic [31:0] OUT_MASK_ONE       = 32'h8e00ffbf;
	localparam logic [31:0] OUT_MASK_TWO       = 32'h03f80000;
	localparam logic [31:0] OUT_MASK_TWO_C1    = 32'h1c000000;
	localparam logic [31:0] OUT_MASK_THREE     = 32'hff0610f8;
	localparam logic [31:0] OUT_MASK_FOUR      = 32'h00003fff;

	// ****************************************
	// Answer sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		SDSR_IDLE = 3'b001,
		SDSR_SEND = 3'b010,
		SDSR_EXC  = 3'b100
	} sdsr_state_t;

endpackage : sdsr_pkg
`default_nettype wire

// *** sdsr_readout.sv ***
// Status readout of input and output devices over holding register reads
`timescale 1ns/1ps
`default_nettype none
module sdsr_readout #(
	parameter bit FW_C1_OR_LATER = 1'b1
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Request from the protocol layer
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [7:0]  req_func,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_qty,
	// Answer towards the protocol layer
	output logic             resp_valid,
	output logic             resp_last,
	output logic             resp_err,
	output logic [7:0]       resp_exc,
	output logic [15:0]      resp_data,
	// Input device states
	input  wire logic [31:0] input_device_word_one,
	input  wire logic [31:0] input_device_word_two,
	input  wire logic [31:0] input_device_word_three,
	input  wire logic [31:0] input_device_word_four,
	// Output device states
	input  wire logic [31:0] output_device_word_one,
	input  wire logic [31:0] output_device_word_two,
	input  wire logic [31:0] output_device_word_three,
	input  wire logic [31:0] output_device_word_four
);

	// ****************************************
	// Masking of unassigned bits
	// ****************************************
	logic [31:0] in_mask_two;
	logic [31:0] out_mask_two;
	logic [127:0] in_group;
	logic [127:0] out_group;

	// Late firmware bits exist only from revision C1 onward
	assign in_mask_two  = sdsr_pkg::IN_MASK_TWO | (FW_C1_OR_LATER ? sdsr_pkg::IN_MASK_TWO_C1 : 32'h00000000);
	assign out_mask_two = sdsr_pkg::OUT_MASK_TWO | (FW_C1_OR_LATER ? sdsr_pkg::OUT_MASK_TWO_C1 : 32'h00000000);

	// Active device reads 1, unassigned bits forced to 0
	assign in_group = {input_device_word_four & sdsr_pkg::IN_MASK_FOUR,
		input_device_word_three & sdsr_pkg::IN_MASK_THREE,
		input_device_word_two & in_mask_two,
		input_device_word_one & sdsr_pkg::IN_MASK_ONE};
	assign out_group = {output_device_word_four & sdsr_pkg::OUT_MASK_FOUR,
		output_device_word_three & sdsr_pkg::OUT_MASK_THREE,
		output_device_word_two & out_mask_two,
		output_device_word_one & sdsr_pkg::OUT_MASK_ONE};

	// ****************************************
	// Register image of one object
	// ****************************************
	function automatic logic [15:0] reg_of(input logic [127:0] snap, input logic [3:0] idx);
		logic [3:0] pos;
		pos = idx - 4'h1;
		if (idx == 4'h0)
		begin
			reg_of = {8'h00, sdsr_pkg::ENTRY_COUNT};
		end
		else
		begin
			reg_of = snap[{pos[2:0], 4'h0} +: 16];
		end
	endfunction : reg_of

	// ****************************************
	// Answer sequencer
	// ****************************************
	sdsr_pkg::sdsr_state_t state_q;
	sdsr_pkg::sdsr_state_t state_d;
	logic [3:0]   idx_q;
	logic [3:0]   idx_d;
	logic [127:0] snap_q;
	logic [127:0] snap_d;
	logic         grp_in_q;
	logic         grp_in_d;
	logic         valid_q;
	logic         valid_d;
	logic         last_q;
	logic         last_d;
	logic         err_q;
	logic         err_d;
	logic [7:0]   exc_q;
	logic [7:0]   exc_d;
	logic [15:0]  data_q;
	logic [15:0]  data_d;
	logic         take;
	logic         is_in;
	logic         is_out;

	// Only one request is served at a time; a new one waits for idle
	assign req_ready = (state_q == sdsr_pkg::SDSR_IDLE);
	assign take      = req_valid && req_ready;
	assign is_in     = (req_addr == sdsr_pkg::ADDR_INPUT_GROUP);
	assign is_out    = (req_addr == sdsr_pkg::ADDR_OUTPUT_GROUP);

	always_comb
	begin
		state_d  = state_q;
		idx_d    = idx_q;
		snap_d   = snap_q;
		grp_in_d = grp_in_q;
		valid_d  = 1'b0;
		last_d   = 1'b0;
		err_d    = 1'b0;
		exc_d    = 8'h00;
		data_d   = 16'h0000;
		unique case (state_q)
			sdsr_pkg::SDSR_IDLE:
			begin
				if (take)
				begin
					valid_d = 1'b1;
					if (req_func != sdsr_pkg::FUNC_READ_HOLDING)
					begin
						state_d = sdsr_pkg::SDSR_EXC;
						err_d   = 1'b1;
						last_d  = 1'b1;
						exc_d   = sdsr_pkg::EXC_BAD_FUNCTION;
					end
					else if (!(is_in || is_out) || req_qty != sdsr_pkg::GROUP_REG_COUNT)
					begin
						// Whole object only: no partial or multi-object reads
						state_d = sdsr_pkg::SDSR_EXC;
						err_d   = 1'b1;
						last_d  = 1'b1;
						exc_d   = sdsr_pkg::EXC_BAD_ADDRESS;
					end
					else
					begin
						// Snapshot keeps all nine registers from one instant
						state_d  = sdsr_pkg::SDSR_SEND;
						snap_d   = is_in ? in_group : out_group;
						grp_in_d = is_in;
						idx_d    = 4'h0;
						data_d   = reg_of(snap_d, 4'h0);
					end
				end
			end
			sdsr_pkg::SDSR_SEND:
			begin
				if (idx_q == sdsr_pkg::LAST_REG_INDEX)
				begin
					state_d = sdsr_pkg::SDSR_IDLE;
				end
				else
				begin
					idx_d   = idx_q + 4'h1;
					valid_d = 1'b1;
					last_d  = (idx_d == sdsr_pkg::LAST_REG_INDEX);
					data_d  = reg_of(snap_q, idx_d);
				end
			end
			sdsr_pkg::SDSR_EXC:
			begin
				state_d = sdsr_pkg::SDSR_IDLE;
			end
			default:
			begin
				state_d = sdsr_pkg::SDSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q  <= sdsr_pkg::SDSR_IDLE;
			idx_q    <= 4'h0;
			snap_q   <= 128'h0;
			grp_in_q <= 1'b0;
			valid_q  <= 1'b0;
			last_q   <= 1'b0;
			err_q    <= 1'b0;
			exc_q    <= 8'h00;
			data_q   <= 16'h0000;
		end
		else
		begin
			state_q  <= state_d;
			idx_q    <= idx_d;
			snap_q   <= snap_d;
			grp_in_q <= grp_in_d;
			valid_q  <= valid_d;
			last_q   <= last_d;
			err_q    <= err_d;
			exc_q    <= exc_d;
			data_q   <= data_d;
		end
	end

	assign resp_valid = valid_q;
	assign resp_last  = last_q;
	assign resp_err   = err_q;
	assign resp_exc   = exc_q;
	assign resp_data  = data_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic take_good;
	assign take_good = take && req_func == sdsr_pkg::FUNC_READ_HOLDING && (is_in || is_out)
		&& req_qty == sdsr_pkg::GROUP_REG_COUNT;

	property p_bad_func;
		take && req_func != sdsr_pkg::FUNC_READ_HOLDING |=> resp_valid && resp_err && resp_last
			&& resp_exc == sdsr_pkg::EXC_BAD_FUNCTION;
	endproperty
	a_bad_func: assert property (p_bad_func) else $error("Wrong function not refused");

	property p_count;
		take_good |=> resp_valid && !resp_err && resp_data == {8'h00, sdsr_pkg::ENTRY_COUNT};
	endproperty
	a_count: assert property (p_count) else $error("Entry count not four");

	property p_in_bit;
		take_good && is_in |-> ##2 resp_data[0] == $past(input_device_word_one[0], 2);
	endproperty
	a_in_bit: assert property (p_in_bit) else $error("Input bit state mismatch");

	property p_word_one;
		take_good && is_in |-> ##2 resp_data[2:0] == $past(input_device_word_one[2:0], 2);
	endproperty
	a_word_one: assert property (p_word_one) else $error("Word one low bits wrong");

	// Early firmware hides the late word two bits of both groups
	property p_c1;
		!FW_C1_OR_LATER |-> (grp_in_q ? snap_q[58:57] == 2'b00 : snap_q[60:58] == 3'b000);
	endproperty
	a_c1: assert property (p_c1) else $error("Late firmware bits present");

	property p_whole_obj;
		take && req_func == sdsr_pkg::FUNC_READ_HOLDING && req_qty != sdsr_pkg::GROUP_REG_COUNT
			|=> resp_err && resp_exc == sdsr_pkg::EXC_BAD_ADDRESS;
	endproperty
	a_whole_obj: assert property (p_whole_obj) else $error("Partial read not refused");

	property p_nine;
		take_good |=> (resp_valid && !resp_last) [*8] ##1 (resp_valid && resp_last) ##1 !resp_valid;
	endproperty
	a_nine: assert property (p_nine) else $error("Object not nine registers");

	property p_out_count;
		take_good && is_out |=> resp_data[7:0] == sdsr_pkg::ENTRY_COUNT;
	endproperty
	a_out_count: assert property (p_out_count) else $error("Output count not four");

	property p_out_bit;
		take_good && is_out |-> ##2 resp_data[0] == $past(output_device_word_one[0], 2);
	endproperty
	a_out_bit: assert property (p_out_bit) else $error("Output bit state mismatch");

	property p_zero;
		grp_in_q |-> (snap_q & ~{sdsr_pkg::IN_MASK_FOUR, sdsr_pkg::IN_MASK_THREE,
			sdsr_pkg::IN_MASK_TWO | sdsr_pkg::IN_MASK_TWO_C1, sdsr_pkg::IN_MASK_ONE}) == 128'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("Unassigned bit not zero");

	property p_out_zero;
		!grp_in_q |-> (snap_q & ~{sdsr_pkg::OUT_MASK_FOUR, sdsr_pkg::OUT_MASK_THREE,
			sdsr_pkg::OUT_MASK_TWO | sdsr_pkg::OUT_MASK_TWO_C1, sdsr_pkg::OUT_MASK_ONE}) == 128'h0;
	endproperty
	a_out_zero: assert property (p_out_zero) else $error("Unassigned output bit not zero");

	property p_out_word;
		take_good && is_out |-> ##2
			resp_data == ($past(output_device_word_one[15:0], 2) & sdsr_pkg::OUT_MASK_ONE[15:0]);
	endproperty
	a_out_word: assert property (p_out_word) else $error("Output word one low half wrong");

	// A second request waits until the ninth register has gone out
	property p_busy;
		take_good |=> (!req_ready) [*8] ##1 (!req_ready) ##1 req_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("Request accepted mid answer");

	property p_exc_one;
		take && !take_good |=> (resp_valid && resp_err && resp_last && !req_ready)
			##1 (!resp_valid && req_ready);
	endproperty
	a_exc_one: assert property (p_exc_one) else $error("Exception answer not one cycle");

	property p_bad_addr;
		take && req_func == sdsr_pkg::FUNC_READ_HOLDING && !(is_in || is_out)
			|=> resp_err && resp_exc == sdsr_pkg::EXC_BAD_ADDRESS;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("Unknown object not refused");

	c_in_read:  cover property (take_good && is_in ##9 resp_last);
	c_out_read: cover property (take_good && is_out ##9 resp_last);
	c_exc:      cover property (take && !take_good ##1 resp_err);
	c_part:     cover property (take && req_qty != sdsr_pkg::GROUP_REG_COUNT ##1 resp_err);

endmodule : sdsr_readout
`default_nettype wire

// *** sdsr_master_model.sv ***
// Modbus master model issuing holding register reads
`timescale 1ns/1ps
`default_nettype none
module sdsr_master_model (
	// Clock
	input  wire logic        clk,
	// Request
	output logic             req_valid,
	input  wire logic        req_ready,
	output logic [7:0]       req_func,
	output logic [15:0]      req_addr,
	output logic [15:0]      req_qty,
	// Answer
	input  wire logic        resp_valid,
	input  wire logic        resp_last,
	input  wire logic        resp_err,
	input  wire logic [7:0]  resp_exc,
	input  wire logic [15:0] resp_data
);
	// ****************************************
	// Read transaction
	// ****************************************
	logic [8:0][15:0] got;
	int          lastat;
	logic        err;
	logic [7:0]  exc;
	int          n;
	initial
	begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_qty = 16'h0000;
	end
	task automatic read(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q, output bit tmo);
		tmo = 1'b1;
		n = 0;
		lastat = -1;
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_func = f;
		req_addr = a;
		req_qty = q;
		for (int k = 0; k < 20 && tmo; k++)
		begin
			@(posedge clk);
			if (req_ready === 1'b1)
				tmo = 1'b0;
		end
		#1;
		// Released lines show the inverse, never a stale copy
		req_valid = 1'b0;
		req_func = ~f;
		req_addr = ~a;
		req_qty = ~q;
		for (int k = 0; k < 11; k++)
		begin
			if (resp_valid === 1'b1 && n < 9)
			begin
				got[n] = resp_data;
				err = resp_err;
				exc = resp_exc;
				if (resp_last === 1'b1)
					lastat = n;
				n++;
			end
			@(posedge clk);
			#1;
		end
	endtask : read
endmodule : sdsr_master_model
`default_nettype wire

// *** sdsr_readout_tb_top.sv ***
// Testbench of the status readout block
`timescale 1ns/1ps
`default_nettype none
module sdsr_readout_tb_top;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        req_valid, req_ready, resp_valid, resp_last, resp_err;
	logic [7:0]  req_func, resp_exc;
	logic [15:0] req_addr, req_qty, resp_data;
	logic        e_req_valid, e_req_ready, e_resp_valid, e_resp_last, e_resp_err;
	logic [7:0]  e_req_func, e_resp_exc;
	logic [15:0] e_req_addr, e_req_qty, e_resp_data;
	bit          e_tmo;
	logic [31:0] iw [4];
	logic [31:0] ow [4];
	logic [31:0] im [4] = '{sdsr_pkg::IN_MASK_ONE, sdsr_pkg::IN_MASK_TWO | sdsr_pkg::IN_MASK_TWO_C1,
		sdsr_pkg::IN_MASK_THREE, sdsr_pkg::IN_MASK_FOUR};
	logic [31:0] om [4] = '{sdsr_pkg::OUT_MASK_ONE, sdsr_pkg::OUT_MASK_TWO | sdsr_pkg::OUT_MASK_TWO_C1,
		sdsr_pkg::OUT_MASK_THREE, sdsr_pkg::OUT_MASK_FOUR};
	logic [15:0] ex [9];
	logic [15:0] ey [9];
	logic [7:0]  bf [4] = '{8'h04, 8'h03, 8'h03, 8'h10};
	logic [15:0] ba [4] = '{16'h2c12, 16'h2c14, 16'h2c13, 16'h2c13};
	logic [15:0] bq [4] = '{16'h0009, 16'h0009, 16'h0008, 16'h0009};
	logic [7:0]  be [4] = '{8'h01, 8'h02, 8'h02, 8'h01};
	int          miscompares = 0;
	int          comparisons = 0;
	bit          tmo, g;
	always #4 clk = ~clk;
	sdsr_readout dut_u (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
		.req_func(req_func), .req_addr(req_addr), .req_qty(req_qty), .resp_valid(resp_valid),
		.resp_last(resp_last), .resp_err(resp_err), .resp_exc(resp_exc), .resp_data(resp_data),
		.input_device_word_one(iw[0]), .input_device_word_two(iw[1]), .input_device_word_three(iw[2]),
		.input_device_word_four(iw[3]), .output_device_word_one(ow[0]), .output_device_word_two(ow[1]),
		.output_device_word_three(ow[2]), .output_device_word_four(ow[3]));
	sdsr_master_model mm_u (.clk(clk), .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
		.req_addr(req_addr), .req_qty(req_qty), .resp_valid(resp_valid), .resp_last(resp_last),
		.resp_err(resp_err), .resp_exc(resp_exc), .resp_data(resp_data));
	// Second copy built for firmware before C1, fed the same device states
	sdsr_readout #(.FW_C1_OR_LATER(1'b0)) dut_early_u (.clk(clk), .nrst(nrst), .req_valid(e_req_valid),
		.req_ready(e_req_ready), .req_func(e_req_func), .req_addr(e_req_addr), .req_qty(e_req_qty),
		.resp_valid(e_resp_valid), .resp_last(e_resp_last), .resp_err(e_resp_err), .resp_exc(e_resp_exc),
		.resp_data(e_resp_data), .input_device_word_one(iw[0]), .input_device_word_two(iw[1]),
		.input_device_word_three(iw[2]), .input_device_word_four(iw[3]), .output_device_word_one(ow[0]),
		.output_device_word_two(ow[1]), .output_device_word_three(ow[2]), .output_device_word_four(ow[3]));
	sdsr_master_model mm_early_u (.clk(clk), .req_valid(e_req_valid), .req_ready(e_req_ready),
		.req_func(e_req_func), .req_addr(e_req_addr), .req_qty(e_req_qty), .resp_valid(e_resp_valid),
		.resp_last(e_resp_last), .resp_err(e_resp_err), .resp_exc(e_resp_exc), .resp_data(e_resp_data));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk_val(input logic [15:0] gv, input logic [15:0] ev);
		comparisons++;
		if (gv !== ev)
		begin
			miscompares++;
			$display("ERROR %0t value %h expected %h", $time, gv, ev);
		end
	endtask : chk_val
	task automatic chk_flag(input logic gv, input logic ev);
		chk_val({15'h0000, gv}, {15'h0000, ev});
	endtask : chk_flag
	task automatic chk_good(input int nv, input int lv, input logic ev, input logic [8:0][15:0] gv, input bit c1);
		chk_val(16'(nv), 16'h0009);
		chk_val(16'(lv), 16'h0008);
		chk_flag(ev, 1'b0);
		chk_val(gv[0], ex[0]);
		for (int i = 1; i < 9; i++)
			chk_val(gv[i], c1 ? ex[i] : ey[i]);
	endtask : chk_good
	task automatic chk_bad(input int nv, input int lv, input logic ev, input logic [7:0] xv, input logic [7:0] xe);
		chk_val(16'(nv), 16'h0001);
		chk_val(16'(lv), 16'h0000);
		chk_flag(ev, 1'b1);
		chk_val({8'h00, xv}, {8'h00, xe});
	endtask : chk_bad
	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// Count first, then each word low half before high half
	function automatic logic [15:0] exp_reg(input bit outg, input int i, input bit c1);
		logic [31:0] w;
		if (i == 0)
			return 16'h0004;
		w = outg ? (ow[(i - 1) / 2] & om[(i - 1) / 2]) : (iw[(i - 1) / 2] & im[(i - 1) / 2]);
		// Early firmware never shows the late word two devices
		if (!c1 && (i - 1) / 2 == 1)
			w = w & ~(outg ? sdsr_pkg::OUT_MASK_TWO_C1 : sdsr_pkg::IN_MASK_TWO_C1);
		return i[0] ? w[15:0] : w[31:16];
	endfunction : exp_reg
	task automatic do_read(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
		fork
			mm_u.read(f, a, q, tmo);
			mm_early_u.read(f, a, q, e_tmo);
			// Inputs move mid-answer; the answer must not follow them
			begin
				repeat (3) @(posedge clk);
				#1;
				foreach (iw[k])
				begin
					iw[k] = ~iw[k];
					ow[k] = ~ow[k];
				end
			end
		join
		if (tmo || e_tmo)
		begin
			miscompares++;
			wrap_up;
		end
	endtask : do_read
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		void'($urandom(32'ha27d7509));
		foreach (iw[k])
		begin
			iw[k] = 32'h00000000;
			ow[k] = 32'h00000000;
		end
		repeat (3) @(posedge clk);
		chk_flag(req_ready, 1'b1);
		chk_flag(resp_valid, 1'b0);
		#1;
		nrst = 1'b1;
		for (int j = 0; j < 24; j++)
		begin
			foreach (iw[k])
			begin
				iw[k] = (j == 0) ? 32'hffffffff : (j == 1) ? 32'h00000000 : $urandom;
				ow[k] = (j == 0) ? 32'hffffffff : (j == 1) ? 32'h00000000 : $urandom;
			end
			g = j[0] ^ $urandom_range(1);
			for (int i = 0; i < 9; i++)
			begin
				ex[i] = exp_reg(g, i, 1'b1);
				ey[i] = exp_reg(g, i, 1'b0);
			end
			do_read(sdsr_pkg::FUNC_READ_HOLDING, g ? 16'h2c13 : 16'h2c12, 16'h0009);
			chk_good(mm_u.n, mm_u.lastat, mm_u.err, mm_u.got, 1'b1);
			chk_good(mm_early_u.n, mm_early_u.lastat, mm_early_u.err, mm_early_u.got, 1'b0);
			repeat ($urandom_range(2))
			begin
				@(posedge clk);
				#1;
			end
		end
		for (int b = 0; b < 4; b++)
		begin
			do_read(bf[b], ba[b], bq[b]);
			chk_bad(mm_u.n, mm_u.lastat, mm_u.err, mm_u.exc, be[b]);
			chk_bad(mm_early_u.n, mm_early_u.lastat, mm_early_u.err, mm_early_u.exc, be[b]);
		end
		wrap_up;
	end
endmodule : sdsr_readout_tb_top
`default_nettype wire
